// file: verilog/pmse_exec.sv
// Behaviour
// RULE1: flags change only for destinations R0 to R7
// RULE2: store pairing: overflow sets sticky latch, else holds
// RULE3: store pairing: V follows overflow; LATCHED_UNDERFLOW_FLAG, C kept
// RULE4: store pairing: N from result sign; UF cleared
// RULE5: store pairing: Z set when product is zero
// RULE6: product A*B to dst1, D-C to dst2
// RULE7: sources sampled at issue, results written after
// RULE8: two indirect plus two register sources accepted
// RULE9: src1/src2 registers; src3/src4 indirect modes
// RULE10: select bits pick R0/R1 and R2/R3
// RULE11: prefix 100011 identifies the instruction word
// RULE12: routing field maps sources onto A, B, D, C
// RULE13: overflow when product top 16 bits disagree
// RULE14: extended mode allows CPU registers in src3/src4
// RULE15: overflow mode bit changes written results
// RULE16: subtract pairing: UF follows integer underflow
// RULE17: overflow mode saturates toward the true sign
// RULE18: single execute cycle when both indirects on-chip
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pmse_defs.svh"

module pmse_exec (
    // Clock and reset.
    input  wire logic                 I_CLOCK,
    input  wire logic                 I_RESETN,
    // Issue port from operand fetch.
    input  wire logic                 I_ISSUE,
    input  wire logic [31:0]          I_INSTR,
    input  wire logic [31:0]          I_SRC1_VAL,
    input  wire logic [31:0]          I_SRC2_VAL,
    input  wire logic [31:0]          I_SRC3_VAL,
    input  wire logic [31:0]          I_SRC4_VAL,
    input  wire logic                 I_SRC3_ONCHIP,
    input  wire logic                 I_SRC4_ONCHIP,
    output logic                      O_READY,
    // Result write ports and status.
    output pmse_pkg::pmse_wr_t        O_WR1,
    output pmse_pkg::pmse_wr_t        O_WR2,
    output pmse_pkg::pmse_flags_t     O_FLAGS,
    output logic                      O_DEC_ERR,
    // Register port.
    input  wire logic [3:0]           I_ADDR,
    input  wire logic [31:0]          I_WDATA,
    input  wire logic                 I_WR,
    input  wire logic                 I_RD,
    output logic [31:0]               O_RDATA,
    output logic                      O_IRQ
);
    import pmse_pkg::*;

    function automatic pmse_kind_t pmse_kind(input logic [7:0] f, input logic ext);
        if (f[7:3] <= `PMSE_IND_MOD_MAX) begin
            pmse_kind = PMSE_KIND_IND;
        end else if (f[7:5] == `PMSE_CPU_TAG && ext) begin
            pmse_kind = PMSE_KIND_CPU;
        end else begin
            pmse_kind = PMSE_KIND_BAD;
        end
    endfunction

    function automatic logic [31:0] pmse_sat(input logic [31:0] v, input logic ovf,
                                             input logic neg, input logic overflow_mode_bit);
        if (ovf && overflow_mode_bit) begin
            pmse_sat = neg ? `PMSE_INT_MIN : `PMSE_INT_MAX;
        end else begin
            pmse_sat = v;
        end
    endfunction

    pmse_state_t        state;
    pmse_state_t        next_state;
    logic               ctrl_ovm;
    logic               ctrl_ext;
    logic [`PMSE_EV_W-1:0] status;
    logic [`PMSE_EV_W-1:0] mask;
    pmse_ops_t          ops;
    pmse_ops_t          iss_ops;
    logic               op_mst;
    logic               op_valid;
    logic [3:0]         d1_sel;
    logic [3:0]         d2_sel;
    logic [3:0]         iss_d1;
    logic [3:0]         iss_d2;
    logic               iss_msub;
    logic               iss_mst;
    logic               iss_valid;
    logic               iss_take;
    pmse_kind_t         k3;
    pmse_kind_t         k4;
    logic [63:0]        prod64;
    logic [32:0]        diff33;
    logic               mul_ovf;
    logic               sub_ovf;
    logic [31:0]        mul_res;
    logic [31:0]        sub_res;
    logic               flag_upd;
    logic               exec;
    pmse_flags_t        next_flags;
    logic [`PMSE_EV_W-1:0] events;
    logic [63:0]        iss_prod;

    // Decode of the word presented with the issue strobe.
    always_comb begin
        iss_msub = I_INSTR[`PMSE_PFX_HI:`PMSE_PFX_LO] == `PMSE_MSUB_PREFIX; // [RULE11]
        iss_mst  = I_INSTR[`PMSE_PFX_HI:`PMSE_PFX_LO] == `PMSE_MST_PREFIX;
        k3 = pmse_kind(I_INSTR[`PMSE_S3_HI:`PMSE_S3_LO], ctrl_ext); // [RULE9] [RULE14]
        k4 = pmse_kind(I_INSTR[`PMSE_S4_HI:`PMSE_S4_LO], ctrl_ext); // [RULE9] [RULE14]
        // Source register fields are three bits wide and always name R0 to R7.
        if (iss_msub) begin
            iss_valid = (k3 != PMSE_KIND_BAD) && (k4 != PMSE_KIND_BAD); // [RULE8]
        end else if (iss_mst) begin
            iss_valid = (k3 != PMSE_KIND_BAD) && (k4 == PMSE_KIND_IND);
        end else begin
            iss_valid = 1'b0;
        end
        iss_ops = '0;
        iss_d1  = `PMSE_EXT_REG_ZERO | {3'h0, I_INSTR[`PMSE_D1_BIT]};  // [RULE10]
        iss_d2  = `PMSE_EXT_REG_TWO  | {3'h0, I_INSTR[`PMSE_D2_BIT]};  // [RULE10]
        if (iss_mst) begin
            iss_ops.a = I_SRC1_VAL;
            iss_ops.b = I_SRC3_VAL;
            iss_ops.d = I_SRC2_VAL;
            iss_d1    = I_INSTR[`PMSE_MST_D1_HI:`PMSE_MST_D1_LO];
            iss_d2    = `PMSE_EXT_REG_ZERO;
        end else begin
            case (I_INSTR[`PMSE_P_HI:`PMSE_P_LO]) // [RULE12]
                `PMSE_P_00: begin
                    iss_ops = '{a: I_SRC3_VAL, b: I_SRC4_VAL, d: I_SRC1_VAL, c: I_SRC2_VAL};
                end
                `PMSE_P_01: begin
                    iss_ops = '{a: I_SRC3_VAL, b: I_SRC1_VAL, d: I_SRC4_VAL, c: I_SRC2_VAL};
                end
                `PMSE_P_10: begin
                    iss_ops = '{a: I_SRC1_VAL, b: I_SRC2_VAL, d: I_SRC3_VAL, c: I_SRC4_VAL};
                end
                default: begin
                    iss_ops = '{a: I_SRC3_VAL, b: I_SRC1_VAL, d: I_SRC2_VAL, c: I_SRC4_VAL};
                end
            endcase
        end
        iss_take = I_ISSUE && O_READY;
        iss_prod = $signed(iss_ops.a) * $signed(iss_ops.b);
    end

    // Execute arithmetic works only on operands captured at issue.
    always_comb begin
        prod64   = $signed(ops.a) * $signed(ops.b);
        mul_ovf  = prod64[`PMSE_PROD_TOP:`PMSE_RES_MSB+1]
                   != {16{prod64[`PMSE_RES_MSB]}}; // [RULE13]
        diff33   = {ops.d[31], ops.d} - {ops.c[31], ops.c}; // [RULE6]
        sub_ovf  = diff33[32] != diff33[31];
        mul_res  = pmse_sat(prod64[31:0], mul_ovf, prod64[63], ctrl_ovm); // [RULE15] [RULE17]
        sub_res  = pmse_sat(diff33[31:0], sub_ovf, diff33[32], ctrl_ovm); // [RULE15] [RULE17]
        exec     = state == PMSE_EXEC;
        flag_upd = op_valid && (d1_sel < `PMSE_EXT_REG_LIMIT); // [RULE1]
        next_flags = O_FLAGS;
        if (op_mst) begin
            next_flags.lv = O_FLAGS.lv | mul_ovf; // [RULE2]
            next_flags.v  = mul_ovf;              // [RULE3]
            next_flags.uf = 1'b0;                 // [RULE4]
            next_flags.n  = mul_res[31];          // [RULE4]
            next_flags.z  = mul_res == 32'h0;     // [RULE5]
        end else begin
            next_flags.lv = O_FLAGS.lv | mul_ovf | sub_ovf;
            next_flags.v  = mul_ovf | (sub_ovf & ~diff33[32]);
            next_flags.uf = sub_ovf & diff33[32]; // [RULE16]
            next_flags.n  = 1'b0;
            next_flags.z  = 1'b0;
        end
        events = '0;
        if (exec) begin
            events[`PMSE_EV_OVF] = flag_upd && next_flags.v;
            events[`PMSE_EV_UNF] = flag_upd && next_flags.uf;
            events[`PMSE_EV_DEC] = !op_valid;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            PMSE_IDLE: begin
                if (iss_take) begin
                    next_state = (I_SRC3_ONCHIP && I_SRC4_ONCHIP) ? PMSE_EXEC
                                                                  : PMSE_WAIT; // [RULE18]
                end
            end
            PMSE_WAIT: begin
                next_state = PMSE_EXEC;
            end
            PMSE_EXEC: begin
                next_state = PMSE_IDLE;
            end
            default: begin
                next_state = PMSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state   <= PMSE_IDLE;
            O_READY <= 1'b0;
        end else begin
            state   <= next_state;
            O_READY <= next_state == PMSE_IDLE;
        end
    end

    // Operands are frozen at issue, so a write in this pair cannot feed its partner.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ops      <= '0;
            op_mst   <= 1'b0;
            op_valid <= 1'b0;
            d1_sel   <= `PMSE_EXT_REG_ZERO;
            d2_sel   <= `PMSE_EXT_REG_ZERO;
        end else if (iss_take) begin
            ops      <= iss_ops; // [RULE7]
            op_mst   <= iss_mst;
            op_valid <= iss_valid;
            d1_sel   <= iss_d1;
            d2_sel   <= iss_d2;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_WR1     <= '0;
            O_WR2     <= '0;
            O_FLAGS   <= '0;
            O_DEC_ERR <= 1'b0;
        end else begin
            O_WR1.we  <= exec && op_valid;
            O_WR2.we  <= exec && op_valid;
            O_DEC_ERR <= exec && !op_valid; // [RULE11]
            if (exec && op_valid) begin
                O_WR1 <= '{we: 1'b1, mem: 1'b0, sel: d1_sel, data: mul_res}; // [RULE6]
                if (op_mst) begin
                    O_WR2 <= '{we: 1'b1, mem: 1'b1, sel: d2_sel, data: ops.d};
                end else begin
                    O_WR2 <= '{we: 1'b1, mem: 1'b0, sel: d2_sel, data: sub_res}; // [RULE6]
                end
                if (flag_upd) begin
                    O_FLAGS <= next_flags; // [RULE1]
                end
            end
        end
    end

    // Register port: control, sticky events, mask and flag readback.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_ovm <= 1'b0;
            ctrl_ext <= 1'b0;
            mask     <= '0;
        end else if (I_WR) begin
            if (I_ADDR == `PMSE_ADDR_CTRL) begin
                ctrl_ovm <= I_WDATA[`PMSE_CTRL_OVM];
                ctrl_ext <= I_WDATA[`PMSE_CTRL_EXT];
            end
            if (I_ADDR == `PMSE_ADDR_MASK) begin
                mask <= I_WDATA[`PMSE_EV_W-1:0];
            end
        end
    end

    // A new event in the clearing cycle stays set.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            status <= '0;
        end else if (I_WR && I_ADDR == `PMSE_ADDR_STATUS) begin
            status <= (status & ~I_WDATA[`PMSE_EV_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_RDATA <= '0;
            O_IRQ   <= 1'b0;
        end else begin
            O_IRQ   <= |(status & mask);
            O_RDATA <= '0;
            if (I_RD) begin
                case (I_ADDR)
                    `PMSE_ADDR_CTRL:   O_RDATA <= {30'h0, ctrl_ext, ctrl_ovm};
                    `PMSE_ADDR_STATUS: O_RDATA <= {29'h0, status};
                    `PMSE_ADDR_MASK:   O_RDATA <= {29'h0, mask};
                    `PMSE_ADDR_FLAGS:  O_RDATA <= {25'h0, O_FLAGS};
                    default:           O_RDATA <= '0;
                endcase
            end
        end
    end

    property p_flags_hold;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        exec && op_valid && !flag_upd |=> O_FLAGS == $past(O_FLAGS);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved"); // [RULE1]

    property p_lv_sticky;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        exec && op_mst && flag_upd |=> O_FLAGS.lv == ($past(O_FLAGS.lv) | $past(mul_ovf));
    endproperty
    a_lv_sticky: assert property (p_lv_sticky) else $error("lv wrong"); // [RULE2]

    property p_v_luf_c;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        exec && op_mst && flag_upd |=> O_FLAGS.v == $past(mul_ovf)
            && $stable(O_FLAGS.latched_underflow_flag) && $stable(O_FLAGS.c);
    endproperty
    a_v_luf_c: assert property (p_v_luf_c) else $error("v luf c wrong"); // [RULE3]

    property p_n_uf;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        exec && op_mst && flag_upd |=> O_FLAGS.n == O_WR1.data[31] && !O_FLAGS.uf;
    endproperty
    a_n_uf: assert property (p_n_uf) else $error("n or uf wrong"); // [RULE4]

    property p_zero;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        exec && op_mst && flag_upd |=> O_FLAGS.z == (O_WR1.data == 32'h0);
    endproperty
    a_zero: assert property (p_zero) else $error("z wrong"); // [RULE5]

    property p_results;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        exec && op_valid && !op_mst && !mul_ovf && !sub_ovf |=>
            O_WR1.data == $past(ops.a) * $past(ops.b) &&
            O_WR2.data == $past(ops.d) - $past(ops.c);
    endproperty
    a_results: assert property (p_results) else $error("result wrong"); // [RULE6]

    property p_sample_issue;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        iss_take && iss_msub && iss_valid && I_SRC3_ONCHIP && I_SRC4_ONCHIP && !ctrl_ovm
            |=> ##1 O_WR1.we && O_WR1.data == $past(iss_prod[31:0], 2);
    endproperty
    a_sample_issue: assert property (p_sample_issue) else $error("sample wrong"); // [RULE7]

    property p_one_cycle;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        iss_take && I_SRC3_ONCHIP && I_SRC4_ONCHIP |=> exec ##1 !exec && O_READY;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("not single cycle"); // [RULE18]

    property p_dest_sel;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        iss_take && iss_msub && iss_valid |=> ##[1:2] O_WR1.we && O_WR1.sel[3:1] == 3'h0
            && O_WR2.sel[3:1] == 3'h1;
    endproperty
    a_dest_sel: assert property (p_dest_sel) else $error("dest wrong"); // [RULE10]

    property p_bad_prefix;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        iss_take && !iss_msub && !iss_mst |=> ##[1:2] O_DEC_ERR && !O_WR1.we;
    endproperty
    a_bad_prefix: assert property (p_bad_prefix) else $error("prefix not refused"); // [RULE11]

    property p_cpu_src;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        iss_take && iss_msub && !ctrl_ext && I_INSTR[`PMSE_S3_HI:`PMSE_S3_HI-2] == 3'h7
            |=> ##[1:2] O_DEC_ERR;
    endproperty
    a_cpu_src: assert property (p_cpu_src) else $error("cpu source accepted"); // [RULE14]

    property p_saturate;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        exec && op_valid && ctrl_ovm && mul_ovf |=>
            O_WR1.data == (prod64[63] ? 32'h80000000 : 32'h7FFFFFFF);
    endproperty
    a_saturate: assert property (p_saturate) else $error("no saturation"); // [RULE17]

    property p_uf;
        @(posedge I_CLOCK) disable iff (!I_RESETN)
        exec && op_valid && !op_mst |=> O_FLAGS.uf == $past(sub_ovf & diff33[32]);
    endproperty
    a_uf: assert property (p_uf) else $error("uf wrong"); // [RULE16]

    c_msub: cover property (@(posedge I_CLOCK) exec && op_valid && !op_mst);
    c_mst: cover property (@(posedge I_CLOCK) exec && op_valid && op_mst && flag_upd);
    c_wait: cover property (@(posedge I_CLOCK) state == PMSE_WAIT);
    c_irq: cover property (@(posedge I_CLOCK) O_IRQ);

endmodule

// file: verilog/pmse_defs.svh
`ifndef PMSE_DEFS_SVH
`define PMSE_DEFS_SVH

// Instruction word layout.
`define PMSE_PFX_HI        31
`define PMSE_PFX_LO        26
`define PMSE_MSUB_PREFIX   6'h23
`define PMSE_MST_PREFIX    6'h30
`define PMSE_P_HI          25
`define PMSE_P_LO          24
`define PMSE_D1_BIT        23
`define PMSE_D2_BIT        22
`define PMSE_MST_D1_HI     25
`define PMSE_MST_D1_LO     22
`define PMSE_S1_HI         21
`define PMSE_S1_LO         19
`define PMSE_S2_HI         18
`define PMSE_S2_LO         16
`define PMSE_S3_HI         15
`define PMSE_S3_LO         8
`define PMSE_S4_HI         7
`define PMSE_S4_LO         0

// Parallel-mode routing codes.
`define PMSE_P_00          2'h0
`define PMSE_P_01          2'h1
`define PMSE_P_10          2'h2
`define PMSE_P_11          2'h3

// Source field classes: indirect modes up to the limit, or any CPU register.
`define PMSE_IND_MOD_MAX   5'h03
`define PMSE_CPU_TAG       3'h7

// Destination register codes.
`define PMSE_EXT_REG_ZERO  4'h0
`define PMSE_EXT_REG_TWO   4'h2
`define PMSE_EXT_REG_LIMIT 4'h8

// Arithmetic limits and overflow window of the 48-bit product.
`define PMSE_INT_MAX       32'h7FFFFFFF
`define PMSE_INT_MIN       32'h80000000
`define PMSE_PROD_TOP      47
`define PMSE_RES_MSB       31

// Register map and bit positions.
`define PMSE_ADDR_CTRL     4'h0
`define PMSE_ADDR_STATUS   4'h4
`define PMSE_ADDR_MASK     4'h8
`define PMSE_ADDR_FLAGS    4'hC
`define PMSE_CTRL_OVM      0
`define PMSE_CTRL_EXT      1
`define PMSE_EV_OVF        0
`define PMSE_EV_DEC        1
`define PMSE_EV_UNF        2
`define PMSE_EV_W          3

`endif

// file: verilog/pmse_pkg.sv
package pmse_pkg;

    typedef struct packed {
        logic latched_underflow_flag;
        logic lv;
        logic uf;
        logic n;
        logic z;
        logic v;
        logic c;
    } pmse_flags_t;

    typedef struct packed {
        logic        we;
        logic        mem;
        logic [3:0]  sel;
        logic [31:0] data;
    } pmse_wr_t;

    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] d;
        logic [31:0] c;
    } pmse_ops_t;

    typedef enum logic [1:0] {PMSE_IDLE, PMSE_WAIT, PMSE_EXEC} pmse_state_t;

    typedef enum logic [1:0] {PMSE_KIND_IND, PMSE_KIND_CPU, PMSE_KIND_BAD} pmse_kind_t;

endpackage

// file: tb/pmse_fetch_model.sv
`timescale 1ns/1ps

module pmse_fetch_model (
    // Clock and handshake from the block.
    input  wire logic        i_clock,
    input  wire logic        i_ready,
    // Issue port toward the block.
    output logic             o_issue,
    output logic [31:0]      o_instr,
    output logic [31:0]      o_src1,
    output logic [31:0]      o_src2,
    output logic [31:0]      o_src3,
    output logic [31:0]      o_src4,
    output logic             o_on3,
    output logic             o_on4
);
    initial begin
        o_issue = 1'b0;
        o_instr = 32'h0;
        {o_src1, o_src2, o_src3, o_src4} = 128'h0;
        {o_on3, o_on4} = 2'h0;
    end

    task automatic issue(input logic [31:0] w, v1, v2, v3, v4, input logic on3, on4);
        @(posedge i_clock);
        while (i_ready !== 1'b1) begin
            @(posedge i_clock);
        end
        o_issue <= 1'b1;
        o_instr <= w;
        {o_src1, o_src2, o_src3, o_src4} <= {v1, v2, v3, v4};
        {o_on3, o_on4} <= {on3, on4};
        @(posedge i_clock);
        o_issue <= 1'b0;
        // Once taken, the operand lines no longer hold the sampled values.
        o_instr <= ~w;
        {o_src1, o_src2, o_src3, o_src4} <= ~{v1, v2, v3, v4};
        {o_on3, o_on4} <= ~{on3, on4};
    endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps

module tb;
    import pmse_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        rdy;
    logic        issue;
    logic [31:0] instr;
    logic [31:0] s1;
    logic [31:0] s2;
    logic [31:0] s3;
    logic [31:0] s4;
    logic        on3;
    logic        on4;
    pmse_wr_t    wr1;
    pmse_wr_t    wr2;
    pmse_flags_t flags;
    logic        dec_err;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        irq;
    pmse_flags_t ef;
    logic        overflow_mode_bit;
    int          err_count;
    int          samples_checked;

    pmse_fetch_model fm (.i_clock(clk), .i_ready(rdy), .o_issue(issue), .o_instr(instr),
        .o_src1(s1), .o_src2(s2), .o_src3(s3), .o_src4(s4), .o_on3(on3), .o_on4(on4));

    pmse_exec uut (.I_CLOCK(clk), .I_RESETN(rst_n), .I_ISSUE(issue), .I_INSTR(instr),
        .I_SRC1_VAL(s1), .I_SRC2_VAL(s2), .I_SRC3_VAL(s3), .I_SRC4_VAL(s4),
        .I_SRC3_ONCHIP(on3), .I_SRC4_ONCHIP(on4), .O_READY(rdy), .O_WR1(wr1), .O_WR2(wr2),
        .O_FLAGS(flags), .O_DEC_ERR(dec_err), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(64'(rdata), 64'(e));
    endtask

    function automatic logic [31:0] sat(input logic [31:0] v, input logic ov, input logic neg);
        return (ov && overflow_mode_bit) ? (neg ? 32'h80000000 : 32'h7FFFFFFF) : v;
    endfunction

    task automatic run(input logic [31:0] w, v1, v2, v3, v4, input logic on,
                       input pmse_wr_t e1, e2, input logic edec);
        int n;
        n = 0;
        fm.issue(w, v1, v2, v3, v4, on, on);
        while (n < 8 && wr1.we !== 1'b1 && dec_err !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(64'(n), on ? 64'h1 : 64'h2);
        chk(64'({dec_err, wr1.we, wr2.we}), 64'({edec, ~edec, ~edec}));
        if (!edec) begin
            chk(64'(wr1), 64'(e1));
            chk(64'(wr2), 64'(e2));
        end
        chk(64'(flags), 64'(ef));
    endtask

    task automatic msub(input logic [1:0] p, input logic d1, d2,
                        input logic [31:0] v1, v2, v3, v4, input logic [15:0] f34, input logic on);
        logic [31:0] a, b, c, d;
        logic [63:0] pr;
        logic [32:0] df;
        logic        mo, po, no;
        case (p)
            2'h0: {a, b, d, c} = {v3, v4, v1, v2};
            2'h1: {a, b, d, c} = {v3, v1, v4, v2};
            2'h2: {a, b, d, c} = {v1, v2, v3, v4};
            default: {a, b, d, c} = {v3, v1, v2, v4};
        endcase
        pr = {{32{a[31]}}, a} * {{32{b[31]}}, b};
        mo = pr[47:32] != {16{pr[31]}};
        df = {d[31], d} - {c[31], c};
        po = !df[32] && df[31];
        no = df[32] && !df[31];
        ef.lv = ef.lv | mo | po | no;
        ef.uf = no;
        ef.n = 1'b0;
        ef.z = 1'b0;
        ef.v = mo | po;
        run({6'h23, p, d1, d2, 3'h1, 3'h2, f34}, v1, v2, v3, v4, on,
            '{1'b1, 1'b0, {3'h0, d1}, sat(pr[31:0], mo, pr[63])},
            '{1'b1, 1'b0, {3'h1, d2}, sat(df[31:0], po | no, no)}, 1'b0);
    endtask

    task automatic mst(input logic [3:0] dst, input logic [31:0] v1, v2, v3);
        logic [63:0] pr;
        logic [31:0] r;
        logic        mo;
        pr = {{32{v1[31]}}, v1} * {{32{v3[31]}}, v3};
        mo = pr[47:32] != {16{pr[31]}};
        r = sat(pr[31:0], mo, pr[63]);
        if (dst < 4'h8) begin
            ef.lv = ef.lv | mo;
            ef.uf = 1'b0;
            ef.n = r[31];
            ef.z = r == 32'h0;
            ef.v = mo;
        end
        run({6'h30, dst, 3'h1, 3'h2, 16'h0809}, v1, v2, v3, 32'h0, 1'b1,
            '{1'b1, 1'b0, dst, r}, '{1'b1, 1'b1, 4'h0, v2}, 1'b0);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        results();
    end

    initial begin
        {rst_n, wr, rd, addr, wdata, overflow_mode_bit, ef} = '0;
        err_count = 0;
        samples_checked = 0;
        repeat (9) @(posedge clk);
        #1;
        chk(64'({rdy, flags}), 64'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        rchk(4'h0, 32'h0);
        rchk(4'h4, 32'h0);
        rchk(4'h8, 32'h0);
        rchk(4'h2, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            msub(2'(i), i[0], i[1], 32'h3, 32'h5, 32'h7, 32'hB, 16'h0809, 1'b1);
        end
        $display("test routing done");
        msub(2'h2, 1'b0, 1'b1, 32'h10000, 32'h8000, 32'h9, 32'h4, 16'h0809, 1'b0);
        rchk(4'h4, 32'h1);
        wreg(4'h8, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk(64'(irq), 64'h1);
        wreg(4'h4, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk(64'(irq), 64'h0);
        msub(2'h2, 1'b0, 1'b0, 32'hFFFF0000, 32'h8000, 32'h1, 32'h1, 16'h0809, 1'b1);
        $display("test overflow done");
        overflow_mode_bit = 1'b1;
        wreg(4'h0, 32'h1);
        msub(2'h2, 1'b1, 1'b1, 32'hFFFF0000, 32'h8001, 32'h80000000, 32'h1, 16'h0809, 1'b1);
        msub(2'h2, 1'b0, 1'b0, 32'h10000, 32'h8001, 32'h7FFFFFFF, 32'hFFFFFFFF, 16'h0809, 1'b1);
        overflow_mode_bit = 1'b0;
        wreg(4'h0, 32'h0);
        msub(2'h2, 1'b0, 1'b0, 32'h2, 32'h3, 32'h80000000, 32'h1, 16'h0809, 1'b1);
        rchk(4'h4, 32'h5);
        wreg(4'h4, 32'h7);
        $display("test saturation done");
        mst(4'h3, 32'h0, 32'hAB, 32'h5);
        mst(4'h5, 32'hFFFFFFFE, 32'h12, 32'h3);
        mst(4'h9, 32'h10000, 32'h34, 32'h8000);
        mst(4'h7, 32'h10000, 32'h56, 32'h8000);
        mst(4'h0, 32'h2, 32'h78, 32'h3);
        $display("test store pairing done");
        rchk(4'h4, 32'h1);
        wreg(4'h4, 32'h7);
        run(32'h88000000 | 32'h00010809, 1, 2, 3, 4, 1'b1, '0, '0, 1'b1);
        run(32'h8C01E009, 1, 2, 3, 4, 1'b1, '0, '0, 1'b1);
        run(32'h8C012009, 1, 2, 3, 4, 1'b1, '0, '0, 1'b1);
        rchk(4'h4, 32'h2);
        wreg(4'h0, 32'h2);
        // A store pairing whose store target is a CPU register is refused.
        run(32'hC00AE0E7, 1, 2, 3, 4, 1'b1, '0, '0, 1'b1);
        msub(2'h0, 1'b1, 1'b0, 32'h4, 32'h6, 32'h9, 32'h2, 16'hE008, 1'b1);
        msub(2'h3, 1'b0, 1'b1, 32'h4, 32'h6, 32'h9, 32'h2, 16'hE0E7, 1'b1);
        rchk(4'hC, 32'(ef));
        wreg(4'hC, 32'h0);
        rchk(4'hC, 32'(ef));
        $display("test decode done");
        results();
    end
endmodule
